/* rtl/sfs_pkg.sv */
// Package with constants for the serial flash SPI front end.
package sfs_pkg;
  // ----------------------------------------------------------------
  // Framing and layout
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8; // Bits in one serial byte.
  localparam int ADDR_W = 24; // Bits in a three-byte array address.
  localparam int SECTOR_LSB = 12; // Sector index starts here (4 KByte sectors).
  localparam int BLOCK_LSB = 15; // Block index starts here (32 KByte blocks).
  localparam int LOCK_BIT = 7; // Position of protect_lock_bit in status.
  localparam int BUSY_BIT = 0; // Position of the busy flag in status.
  localparam logic [7:0] STATUS_RST = 8'h0C; // Status after reset.
  localparam logic [7:0] CMD_RDSR = 8'h05; // Read status opcode.
  localparam logic [7:0] CMD_WRITE_STATUS_COMMAND = 8'h01; // write_status_command opcode.
  localparam logic [2:0] BIT_LAST = 3'h7; // Bit count of a byte's last bit.
  localparam logic [1:0] ADDR_BYTES = 2'h3; // Address bytes after opcode.
endpackage

/* rtl/sfs_sync.sv */
// Two flip-flop synchroniser for one level.
module sfs_sync (
  input wire logic clk,
  input wire logic d,
  output logic q
);
  logic meta_r; // First stage; read only by the second stage.
  // Plain two-stage chain; no reset so no port value lands in reset logic.
  always_ff @(posedge clk) begin
    meta_r <= d;
    q <= meta_r;
  end
endmodule

/* rtl/sfs_front_end.sv */
// Serial flash SPI front end: link shifter on the serial clock, control on mclk.
// Contract
// R1: Sample input bits on serial clock rising edge.
// R2: Shift output bits on serial clock falling edge.
// R3: New frame only on select falling edge.
// R4: Master holds select low whole command.
// R5: Work in SPI mode 0 and 3.
// R6: Master parks clock per mode when idle.
// R7: Four lines; device drives only serial output.
// R8: Pause freezes transfer, keeps sequence state.
// R9: Write protect pin gates lock bit.
// R10: Decode 4 KByte sectors, 32 KByte blocks.
// R11: Completion reported by readable busy status.
// R12: Pause changes only while clock low.
// R13: Paused: output released, inputs ignored.
// R14: Deselect during pause resets interface logic.
// R15: Refuse status write when protected and locked.
// R16: Bytes travel MSB first; first is opcode.
// R17: Deselect releases output, drops partial byte.
module sfs_front_end (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic busy,
  output logic so,
  output logic so_oe,
  output logic [7:0] cmd_opcode,
  output logic cmd_valid,
  output logic [11:0] sector_idx,
  output logic [8:0] block_idx,
  output logic [7:0] status_out,
  output logic write_status_command_refused
);
  // ----------------------------------------------------------------
  // Link domain: clocked by the master's serial clock
  // ----------------------------------------------------------------
  logic hold_act_r; // Pause state, changed on falling clock edges; deselect also clears it at any clock level.
  logic [2:0] bit_cnt_r; // Bit position inside current byte.
  logic [7:0] shin_r; // Incoming shift register.
  logic [7:0] shout_r; // Outgoing shift register.
  logic first_r; // Next byte is the opcode.
  logic [7:0] op_r; // Opcode of this frame.
  logic [1:0] abytes_r; // Address bytes seen so far.
  logic [23:0] addr_r; // Collected address.
  logic byte_tgl_r; // Toggles on each completed byte.
  logic [7:0] byte_r; // Last completed byte.
  logic [7:0] stat_snap; // Status synchronised for loading the output shifter.
  logic [7:0] status_r; // Status register on mclk.
  logic [7:0] in_byte; // Byte as it completes.

  assign in_byte = {shin_r[6:0], si}; // R16

  // Pause is sampled on the falling clock edge, so it changes in the low phase.
  // Deselect clears it too, so a new frame always starts unpaused.
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      hold_act_r <= 1'b0; // R14
    end else begin
      hold_act_r <= ~hold_n; // R12
    end
  end

  // Input capture on rising edges; select going high clears the frame state at any clock level.
  // Works for modes 0 and 3 since only the edge direction matters.
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_r <= 3'h0; // R17
      shin_r <= 8'h00;
      first_r <= 1'b1; // R3
      abytes_r <= 2'h0;
      byte_tgl_r <= 1'b0;
      op_r <= 8'h00;
    end else if (!hold_act_r && hold_n) begin // R8 R13
      shin_r <= in_byte; // R1 R5
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (bit_cnt_r == sfs_pkg::BIT_LAST) begin
        byte_tgl_r <= ~byte_tgl_r;
        first_r <= 1'b0;
        if (first_r) begin
          op_r <= in_byte; // R16
        end else if (abytes_r != sfs_pkg::ADDR_BYTES) begin
          abytes_r <= abytes_r + 2'h1;
        end
      end
    end
  end

  // Completed bytes and the address are kept through deselect.
  // The mclk side reads them a few cycles after the byte toggle, so clearing them
  // at select high could pull them away under it; the address restarts at each opcode.
  always_ff @(posedge sck) begin
    if (!cs_n && !hold_act_r && hold_n && bit_cnt_r == sfs_pkg::BIT_LAST) begin
      byte_r <= in_byte; // R1
      if (first_r) begin
        addr_r <= 24'h00_0000;
      end else if (abytes_r != sfs_pkg::ADDR_BYTES) begin
        addr_r <= {addr_r[15:0], in_byte}; // R10
      end
    end
  end

  // Output shifts on falling edges; status is loaded after a read-status opcode.
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      shout_r <= 8'h00;
    end else if (!hold_act_r && hold_n) begin
      if (bit_cnt_r == 3'h0 && !first_r && op_r == sfs_pkg::CMD_RDSR) begin
        shout_r <= stat_snap; // R2 R11
      end else begin
        shout_r <= {shout_r[6:0], 1'b0}; // R2
      end
    end
  end

  assign so = shout_r[7]; // R16
  assign so_oe = ~cs_n & ~hold_act_r; // R7 R13 R17

  // Status bits cross into the link domain; they change only on slow events.
  genvar gi;
  for (gi = 0; gi < 8; gi++) begin : g_stat
    sfs_sync u_s (.clk(sck), .d(status_r[gi]), .q(stat_snap[gi]));
  end

  // ----------------------------------------------------------------
  // Control domain on mclk
  // ----------------------------------------------------------------
  logic tgl_s; // Synchronised byte toggle.
  logic tgl_d_r; // Previous toggle.
  logic cs_s; // Synchronised select.
  logic wp_s; // Synchronised write protect.
  logic busy_s; // Synchronised busy.
  logic byte_ev; // One-cycle byte event.
  logic [7:0] opc_r; // Opcode copy in mclk domain.
  logic [7:0] byte_m_r; // Byte copy in mclk domain.
  logic [1:0] nbytes_r; // Set to 1 once the frame's opcode byte is seen on mclk side.
  logic [23:0] addr_m_r; // Address copy.

  sfs_sync u_tg (.clk(mclk), .d(byte_tgl_r), .q(tgl_s));
  sfs_sync u_cs (.clk(mclk), .d(cs_n), .q(cs_s));
  sfs_sync u_wp (.clk(mclk), .d(wp_n), .q(wp_s));
  sfs_sync u_bz (.clk(mclk), .d(busy), .q(busy_s));

  assign byte_ev = tgl_s ^ tgl_d_r;

  // Byte capture: held link bytes are stable for eight serial clocks after the toggle.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tgl_d_r <= 1'b0;
      opc_r <= 8'h00;
      byte_m_r <= 8'h00;
      nbytes_r <= 2'h0;
      cmd_valid <= 1'b0;
      addr_m_r <= 24'h00_0000;
    end else begin
      tgl_d_r <= cs_s ? 1'b0 : tgl_s;
      cmd_valid <= 1'b0;
      if (cs_s) begin
        nbytes_r <= 2'h0; // R17
      end else if (byte_ev) begin
        byte_m_r <= byte_r;
        if (nbytes_r == 2'h0) begin
          opc_r <= byte_r; // R16
          cmd_valid <= 1'b1;
          nbytes_r <= 2'h1;
        end else begin
          addr_m_r <= addr_r;
        end
      end
    end
  end

  // Status register; a status write at frame end is gated by the protect pin.
  logic wr_pend_r; // Status write byte received.
  logic locked; // Lock honoured and set.
  assign locked = ~wp_s & status_r[sfs_pkg::LOCK_BIT]; // R9 R15
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      status_r <= sfs_pkg::STATUS_RST;
      wr_pend_r <= 1'b0;
      write_status_command_refused <= 1'b0;
    end else begin
      status_r[sfs_pkg::BUSY_BIT] <= busy_s; // R11
      write_status_command_refused <= 1'b0;
      if (byte_ev && nbytes_r != 2'h0 && opc_r == sfs_pkg::CMD_WRITE_STATUS_COMMAND) begin
        wr_pend_r <= 1'b1;
      end else if (cs_s && wr_pend_r) begin
        wr_pend_r <= 1'b0;
        if (locked) begin
          write_status_command_refused <= 1'b1; // R15
        end else begin
          status_r[7] <= byte_m_r[7];
          status_r[3:2] <= byte_m_r[3:2];
        end
      end else if (cs_s) begin
        wr_pend_r <= 1'b0;
      end
    end
  end

  // Register the decoded outputs.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmd_opcode <= 8'h00;
      sector_idx <= 12'h000;
      block_idx <= 9'h000;
      status_out <= sfs_pkg::STATUS_RST;
    end else begin
      cmd_opcode <= opc_r;
      sector_idx <= addr_m_r[23:sfs_pkg::SECTOR_LSB]; // R10
      block_idx <= addr_m_r[23:sfs_pkg::BLOCK_LSB]; // R10
      status_out <= status_r;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_deselect_release: assert property (@(posedge mclk) disable iff (!rst_n) // R17
    cs_n |-> !so_oe) else $error("Output driven while deselected.");
  a_pause_release: assert property (@(posedge mclk) disable iff (!rst_n) // R13
    hold_act_r |-> !so_oe) else $error("Output driven while paused.");
  a_lock_refuse: assert property (@(posedge mclk) disable iff (!rst_n) // R15
    write_status_command_refused |-> $stable(status_r[7]) && $past(locked)) else $error("Locked status changed.");
  a_sector_map: assert property (@(posedge mclk) disable iff (!rst_n) // R10
    ##1 sector_idx[11:3] == block_idx) else $error("Block not overlay of sectors.");
  a_busy_seen: assert property (@(posedge mclk) disable iff (!rst_n) // R11
    $rose(busy_s) |=> status_r[0]) else $error("Busy not reported.");
  a_cmd_pulse: assert property (@(posedge mclk) disable iff (!rst_n) // R16
    cmd_valid |=> !cmd_valid) else $error("Command pulse too long.");
  a_sample_rise: assert property (@(posedge sck) disable iff (cs_n) // R1
    (!hold_act_r && hold_n) |=> shin_r[0] == $past(si)) else $error("Input not sampled.");
  a_hold_freeze: assert property (@(posedge sck) disable iff (cs_n) // R8
    hold_act_r |=> $stable(bit_cnt_r)) else $error("Paused count moved.");
endmodule

/* tb/sfs_spi_master.sv */
// SPI master model that runs frames of whole bytes into the flash front end.
module sfs_spi_master (
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic hold_n,
  input wire logic so,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle link: deselected, clock parked low, pause released.
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b1;
    hold_n = 1'b1;
  end
  // ---------------------------------------------------------------
  // One frame; the clock toggles only inside it.
  // ---------------------------------------------------------------
  task automatic frame(input bit m3, input logic [31:0] tx, input int nbits, input int hb,
      output logic [7:0] rx, output logic oe_held);
    oe_held = 1'b0;
    sck = m3;
    #7 cs_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      // Pause is raised a little after the rising edge, while the clock is high,
      // so it takes hold at the next low phase and never races the edge itself.
      if (i == hb) begin
        #3 hold_n = 1'b0;
        #3 sck = 1'b0;
        #6 oe_held = so_oe;
        sck = 1'b1;
        si = ~si;
        #6 hold_n = 1'b1;
      end
      #6 sck = 1'b0;
      si = tx[i];
      #6 sck = 1'b1;
      if (i < 8) rx[i] = so;
    end
    #6 sck = m3;
    #6 cs_n = 1'b1;
    si = ~si; // A released line shows the inverse, not the last bit.
  endtask
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the serial flash SPI front end.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, sck, cs_n, si, hold_n, wp_n, busy, so, so_oe, cmd_valid, write_status_command_refused, oe_held, pend;
  logic [7:0] cmd_opcode, status_out, rx;
  logic [11:0] sector_idx;
  logic [8:0] block_idx;
  logic [7:0] op_q[$];
  int mismatches, checks, refusals, cyc;
  int seed = 46;
  sfs_front_end u_sfs_front_end (.mclk(mclk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .busy(busy), .so(so), .so_oe(so_oe), .cmd_opcode(cmd_opcode),
    .cmd_valid(cmd_valid), .sector_idx(sector_idx), .block_idx(block_idx), .status_out(status_out),
    .write_status_command_refused(write_status_command_refused));
  sfs_spi_master u_sfs_spi_master (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe));
  // The system clock free-runs; the link clock comes from the master model.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watcher: the opcode follows its valid pulse by one cycle; a hang is cut short.
  always @(negedge mclk) begin
    if (pend) check(cmd_opcode, op_q.pop_front());
    pend = cmd_valid;
    if (write_status_command_refused === 1'b1) refusals++;
    cyc++;
    if (cyc > 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  // One frame in a random mode; busy is random and settles before the frame.
  task automatic run(input logic [7:0] op, input logic [7:0] d, input logic [7:0] exp, input int hb, input logic wp);
    bit m3;
    int r;
    @(negedge mclk);
    r = $random(seed);
    busy = r[0];
    wp_n = wp;
    m3 = r[1];
    repeat (8) @(negedge mclk);
    op_q.push_back(op);
    u_sfs_spi_master.frame(m3, {16'h0000, op, d}, 16, hb, rx, oe_held);
    if (op == sfs_pkg::CMD_RDSR) begin
      check(rx, exp | {7'h00, busy});
      check(status_out, exp | {7'h00, busy});
    end
    if (hb >= 0) check({7'h00, oe_held}, 8'h00);
    repeat (30) @(negedge mclk);
    check({7'h00, so_oe}, 8'h00);
  endtask
  // Opcode plus a random three-byte address in a random mode; both indices are checked.
  task automatic addr_run(input logic [7:0] op);
    int r;
    logic [23:0] a;
    logic [11:0] es;
    logic [8:0] eb;
    @(negedge mclk);
    r = $random(seed);
    a = r[23:0];
    es = 12'(a >> sfs_pkg::SECTOR_LSB);
    eb = 9'(a >> sfs_pkg::BLOCK_LSB);
    op_q.push_back(op);
    u_sfs_spi_master.frame(r[31], {op, a}, 32, -1, rx, oe_held);
    repeat (30) @(negedge mclk);
    check(sector_idx[7:0], es[7:0]);
    check({4'h0, sector_idx[11:8]}, {4'h0, es[11:8]});
    check(block_idx[7:0], eb[7:0]);
    check({7'h00, block_idx[8]}, {7'h00, eb[8]});
    check({7'h00, so_oe}, 8'h00);
  endtask
  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    busy = 1'b0;
    pend = 1'b0;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    run(sfs_pkg::CMD_RDSR, 8'h00, sfs_pkg::STATUS_RST, 12, 1'b1);
    run(sfs_pkg::CMD_WRITE_STATUS_COMMAND, 8'h8C, 8'h00, -1, 1'b0);
    run(sfs_pkg::CMD_RDSR, 8'h00, 8'h8C, -1, 1'b0);
    run(sfs_pkg::CMD_WRITE_STATUS_COMMAND, 8'h00, 8'h00, -1, 1'b0);
    run(sfs_pkg::CMD_RDSR, 8'h00, 8'h8C, -1, 1'b1);
    run(sfs_pkg::CMD_WRITE_STATUS_COMMAND, 8'h0C, 8'h00, -1, 1'b1);
    run(sfs_pkg::CMD_RDSR, 8'h00, 8'h0C, 10, 1'b1);
    addr_run(8'hA5);
    addr_run(8'h5A);
    check(refusals[7:0], 8'h01);
    end_of_test();
  end
endmodule
